/* File: verilog/gdf_params.svh */
// constants for the gate driver global flag block
`ifndef GDF_PARAMS_SVH
`define GDF_PARAMS_SVH
// How it works
// - config bit 7 set routes an analog test signal onto the enable pin, clear means normal operation.
// - with the test output on, the dead time field picks temperature, dac or high side supply for the pin.
// - the amplifier off bit keeps the sense amplifiers powered at 0 and powers them down at 1.
// - writing a one to a flag bit clears that flag, writing a zero leaves it alone.
// - taking the enable input low and high again clears every flag but reset seen and prewarning.
// - clearing a flag never re-enables a shorted transistor; its gate input must go low first.
// - flag bit 0 is set by every reset, and reset returns all registers to their reset values.
// - a write-one clear of reset seen only works while the enable input is high.
// - the prewarning flag latches above the prewarning level and causes no protective action.
// - flag bit 3 latches a pump undervoltage and is kept for information.
// - the shutdown flag ignores clears while overtemperature persists.
// - the shutdown flag is ored into the fault status output.

`define GDF_FRAME_BITS 6'h28
`define GDF_ADDR_CONF 7'h00
`define GDF_ADDR_FLAGS 7'h01
`define GDF_ADDR_DTIME 7'h0A
`define GDF_BIT_AMP_OFF 6
`define GDF_BIT_TEST 7
`define GDF_FLAG_RESET 0
`define GDF_FLAG_PREWARN 1
`define GDF_FLAG_SHUTDOWN 2
`define GDF_FLAG_PUMP_UV 3
`define GDF_FLAGS_RST 4'h1
`define GDF_CONF_RST 1'h0
`define GDF_DTIME_RST 2'h0
`endif

/* File: verilog/gdf_pkg.sv */
// types shared by the global flag block
package gdf_pkg;
  typedef enum logic {GDF_IDLE, GDF_SHIFT} gdf_spi_state_e;
  typedef enum logic [1:0] {GDF_TSEL_TEMP, GDF_TSEL_DAC, GDF_TSEL_HSUPPLY, GDF_TSEL_NONE} gdf_test_sel_e;
  typedef logic [3:0] gdf_flags_t;
  typedef logic [6:0] gdf_addr_t;
endpackage

/* File: verilog/gdf_flag_cell.sv */
// one sticky status flag with set priority
`timescale 1ns/1ps
module gdf_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic setCond,
  input wire logic clearReq,
  output logic flagNow,
  output logic flagNext
);
  logic flag_reg;
  logic flag_next;

  // ==========================================
  // next value
  always_comb begin
    flag_next = setCond | (flag_reg & ~clearReq);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_reg <= RESET_VAL;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flagNow = flag_reg;
  assign flagNext = flag_next;

  // ==========================================
  // checks
  chk_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    setCond |=> flag_reg)
    else $error("flag lost its set event");
  chk_clear_acts: assert property (@(posedge clk_sys) disable iff (rst)
    (clearReq && !setCond) |=> !flag_reg)
    else $error("flag ignored a clear");
endmodule

/* File: verilog/gdf_global_flags.sv */
// global config tail bits, global flags and register port
`timescale 1ns/1ps
`include "gdf_params.svh"
module gdf_global_flags (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiSdi,
  output logic spiSdo,
  input wire logic drvEnable,
  input wire logic tempPrewarn,
  input wire logic tempShutdown,
  input wire logic pumpUv,
  input wire logic [5:0] shortDetect,
  input wire logic [2:0] highSideGateInput,
  input wire logic [2:0] lowSideGateInput,
  output logic [2:0] highSideGateOut,
  output logic [2:0] lowSideGateOut,
  output logic ampPowerDown,
  output logic testOutEnable,
  output logic [1:0] testSelect,
  output logic faultStatus
);
  // ==========================================
  // register read mux
  function automatic logic [31:0] gdf_read(
    input gdf_pkg::gdf_addr_t addr,
    input logic ampOff,
    input logic testOn,
    input gdf_pkg::gdf_flags_t flags,
    input logic [1:0] dtime
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    if (addr == `GDF_ADDR_CONF) begin
      word[`GDF_BIT_AMP_OFF] = ampOff;
      word[`GDF_BIT_TEST] = testOn;
    end else if (addr == `GDF_ADDR_FLAGS) begin
      word[3:0] = flags;
    end else if (addr == `GDF_ADDR_DTIME) begin
      word[1:0] = dtime;
    end
    return word;
  endfunction

  // ==========================================
  // serial port, 40 bit frames: write bit, 7 bit address, 32 bit data
  // the msb stands from the select edge on, so a host takes each bit just before its sck fall
  gdf_pkg::gdf_spi_state_e state_reg, state_next;
  logic [5:0] bitCnt_reg, bitCnt_next;
  logic [39:0] shiftIn_reg, shiftIn_next;
  logic [39:0] shiftOut_reg, shiftOut_next;
  logic sckPrev_reg, sckPrev_next;
  logic sdo_reg, sdo_next;
  gdf_pkg::gdf_addr_t readAddr_reg, readAddr_next;
  logic wrStrobe;
  gdf_pkg::gdf_addr_t wrAddr;
  logic [31:0] wrData;
  gdf_pkg::gdf_flags_t flagsNow, flagsNext;
  logic ampOff_reg, ampOff_next;
  logic testOn_reg, testOn_next;
  logic [1:0] dtime_reg, dtime_next;

  // pins are synchronous, so sck edges are found against its last sample
  always_comb begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    shiftIn_next = shiftIn_reg;
    shiftOut_next = shiftOut_reg;
    sckPrev_next = spiSck;
    sdo_next = sdo_reg;
    readAddr_next = readAddr_reg;
    wrStrobe = 1'b0;
    wrAddr = shiftIn_reg[38:32];
    wrData = shiftIn_reg[31:0];
    case (state_reg)
      gdf_pkg::GDF_IDLE: begin
        if (!spiCsN) begin
          state_next = gdf_pkg::GDF_SHIFT;
          bitCnt_next = 6'h00;
          shiftOut_next = {4'h0, flagsNow, gdf_read(readAddr_reg, ampOff_reg, testOn_reg, flagsNow, dtime_reg)};
          sdo_next = shiftOut_next[39];
        end
      end
      gdf_pkg::GDF_SHIFT: begin
        if (spiCsN) begin
          state_next = gdf_pkg::GDF_IDLE;
          // short or long frames are dropped whole
          if (bitCnt_reg == `GDF_FRAME_BITS) begin
            wrStrobe = shiftIn_reg[39];
            readAddr_next = shiftIn_reg[38:32];
          end
        end else begin
          if (spiSck && !sckPrev_reg && bitCnt_reg != 6'h3F) begin
            shiftIn_next = {shiftIn_reg[38:0], spiSdi};
            bitCnt_next = bitCnt_reg + 6'h01;
          end
          if (!spiSck && sckPrev_reg) begin
            shiftOut_next = {shiftOut_reg[38:0], 1'b0};
            sdo_next = shiftOut_reg[38];
          end
        end
      end
      default: state_next = gdf_pkg::GDF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= gdf_pkg::GDF_IDLE;
      bitCnt_reg <= 6'h00;
      shiftIn_reg <= 40'h00_0000_0000;
      shiftOut_reg <= 40'h00_0000_0000;
      sckPrev_reg <= 1'b1;
      sdo_reg <= 1'b0;
      readAddr_reg <= `GDF_ADDR_FLAGS;
    end else begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      shiftIn_reg <= shiftIn_next;
      shiftOut_reg <= shiftOut_next;
      sckPrev_reg <= sckPrev_next;
      sdo_reg <= sdo_next;
      readAddr_reg <= readAddr_next;
    end
  end

  assign spiSdo = sdo_reg;

  // ==========================================
  // configuration bits
  always_comb begin
    ampOff_next = ampOff_reg;
    testOn_next = testOn_reg;
    dtime_next = dtime_reg;
    if (wrStrobe && wrAddr == `GDF_ADDR_CONF) begin
      ampOff_next = wrData[`GDF_BIT_AMP_OFF];
      testOn_next = wrData[`GDF_BIT_TEST];
    end else if (wrStrobe && wrAddr == `GDF_ADDR_DTIME) begin
      dtime_next = wrData[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ampOff_reg <= `GDF_CONF_RST;
      testOn_reg <= `GDF_CONF_RST;
      dtime_reg <= `GDF_DTIME_RST;
    end else begin
      ampOff_reg <= ampOff_next;
      testOn_reg <= testOn_next;
      dtime_reg <= dtime_next;
    end
  end

  // ==========================================
  // global flags
  logic enPrev_reg, enPrev_next;
  logic enToggle;
  gdf_pkg::gdf_flags_t w1c;
  gdf_pkg::gdf_flags_t setVec;
  gdf_pkg::gdf_flags_t clrVec;
  // reset value per flag, indexed so each cell takes exactly one bit
  localparam gdf_pkg::gdf_flags_t FLAGS_RST = `GDF_FLAGS_RST;

  // held high through reset so an enable already high is not seen as a toggle
  always_comb begin
    enPrev_next = drvEnable;
    enToggle = drvEnable && !enPrev_reg;
    w1c = (wrStrobe && wrAddr == `GDF_ADDR_FLAGS) ? wrData[3:0] : 4'h0;
    setVec = 4'h0;
    setVec[`GDF_FLAG_PREWARN] = tempPrewarn;
    setVec[`GDF_FLAG_SHUTDOWN] = tempShutdown;
    setVec[`GDF_FLAG_PUMP_UV] = pumpUv;
    clrVec = w1c;
    clrVec[`GDF_FLAG_RESET] = w1c[`GDF_FLAG_RESET] & drvEnable;
    clrVec[`GDF_FLAG_SHUTDOWN] = w1c[`GDF_FLAG_SHUTDOWN] | enToggle;
    clrVec[`GDF_FLAG_PUMP_UV] = w1c[`GDF_FLAG_PUMP_UV] | enToggle;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enPrev_reg <= 1'b1;
    end else begin
      enPrev_reg <= enPrev_next;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_flag
    gdf_flag_cell #(
      .RESET_VAL(FLAGS_RST[i])
    ) u_cell (
      .clk_sys(clk_sys),
      .rst(rst),
      .setCond(setVec[i]),
      .clearReq(clrVec[i]),
      .flagNow(flagsNow[i]),
      .flagNext(flagsNext[i])
    );
  end

  // ==========================================
  // short lockout and pin outputs
  logic [5:0] shortLatch_reg, shortLatch_next;
  logic [5:0] gateOut_reg, gateOut_next;
  logic [5:0] gateIn;
  logic fault_reg, fault_next;
  logic ampPd_reg, ampPd_next;
  logic testEn_reg, testEn_next;
  logic [1:0] tsel_reg, tsel_next;

  // a short is only released by its own gate input going low, never by a flag write
  always_comb begin
    gateIn = {highSideGateInput, lowSideGateInput};
    shortLatch_next = shortDetect | (shortLatch_reg & gateIn);
    gateOut_next = gateIn & ~shortLatch_next;
    fault_next = flagsNext[`GDF_FLAG_SHUTDOWN] | (|shortLatch_next);
    ampPd_next = ampOff_next;
    testEn_next = testOn_next;
    tsel_next = testOn_next ? dtime_next : gdf_pkg::GDF_TSEL_NONE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shortLatch_reg <= 6'h00;
      gateOut_reg <= 6'h00;
      fault_reg <= 1'b0;
      ampPd_reg <= `GDF_CONF_RST;
      testEn_reg <= `GDF_CONF_RST;
      tsel_reg <= gdf_pkg::GDF_TSEL_NONE;
    end else begin
      shortLatch_reg <= shortLatch_next;
      gateOut_reg <= gateOut_next;
      fault_reg <= fault_next;
      ampPd_reg <= ampPd_next;
      testEn_reg <= testEn_next;
      tsel_reg <= tsel_next;
    end
  end

  assign highSideGateOut = gateOut_reg[5:3];
  assign lowSideGateOut = gateOut_reg[2:0];
  assign ampPowerDown = ampPd_reg;
  assign testOutEnable = testEn_reg;
  assign testSelect = tsel_reg;
  assign faultStatus = fault_reg;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence sEnLow;
    !drvEnable;
  endsequence
  sequence sEnHigh;
    drvEnable;
  endsequence
  sequence sFlagWrite;
    wrStrobe && wrAddr == `GDF_ADDR_FLAGS;
  endsequence

  chk_test_route: assert property (
    (wrStrobe && wrAddr == `GDF_ADDR_CONF) |=> testOutEnable == $past(wrData[`GDF_BIT_TEST]))
    else $error("test output enable does not follow config write");
  chk_test_select: assert property (
    testOn_reg && !wrStrobe |=> testSelect == $past(dtime_reg))
    else $error("test select does not follow dead time field");
  chk_amp_power: assert property (
    (wrStrobe && wrAddr == `GDF_ADDR_CONF) |=> ampPowerDown == $past(wrData[`GDF_BIT_AMP_OFF]))
    else $error("amplifier power down does not follow config write");
  chk_write_zero_keeps: assert property (
    (sFlagWrite and (flagsNow[`GDF_FLAG_PUMP_UV] && !wrData[`GDF_FLAG_PUMP_UV] && !enToggle))
    |=> flagsNow[`GDF_FLAG_PUMP_UV])
    else $error("zero write cleared a flag");
  chk_toggle_clears: assert property (
    (sEnLow ##1 (sEnHigh and (!tempShutdown && !pumpUv))) |=> flagsNow[3:2] == 2'h0)
    else $error("enable toggle left a flag set");
  chk_toggle_keeps: assert property (
    (sEnLow ##1 (sEnHigh and (flagsNow[`GDF_FLAG_RESET] && flagsNow[`GDF_FLAG_PREWARN] && !wrStrobe)))
    |=> flagsNow[1:0] == 2'h3)
    else $error("enable toggle cleared reset seen or prewarning");
  chk_short_blocks: assert property (
    (shortLatch_reg & gateIn) != 6'h00 |=> (gateOut_reg & $past(shortLatch_reg & gateIn)) == 6'h00)
    else $error("shorted transistor re-enabled while its input is high");
  chk_reset_seen_gated: assert property (
    (sFlagWrite and (!drvEnable && flagsNow[`GDF_FLAG_RESET])) |=> flagsNow[`GDF_FLAG_RESET])
    else $error("reset seen cleared with enable low");
  chk_shutdown_holds: assert property (
    (tempShutdown ##1 (sFlagWrite and tempShutdown))
    |-> flagsNow[`GDF_FLAG_SHUTDOWN] ##1 flagsNow[`GDF_FLAG_SHUTDOWN])
    else $error("shutdown flag cleared during overtemperature");
  chk_status_or: assert property (
    flagsNow[`GDF_FLAG_SHUTDOWN] |-> faultStatus)
    else $error("fault status low with shutdown flag set");
  chk_prewarn_latch: assert property (
    tempPrewarn |=> flagsNow[`GDF_FLAG_PREWARN])
    else $error("prewarning flag missed its event");
  chk_prewarn_clear: assert property (
    (sFlagWrite and (wrData[`GDF_FLAG_PREWARN] && !tempPrewarn))
    |=> !flagsNow[`GDF_FLAG_PREWARN])
    else $error("write one left the prewarning flag set");
  chk_short_fault: assert property (
    (|shortLatch_reg) |-> faultStatus)
    else $error("fault status low with a short latched");
endmodule

/* File: test/gdf_host_model.sv */
// host model driving the serial register port of the flag block
`timescale 1ns/1ps
module gdf_host_model (
  input wire logic clk_sys,
  output logic spiCsN,
  output logic spiSck,
  output logic spiSdi,
  input wire logic spiSdo
);
  initial begin
    spiCsN = 1'b1;
    spiSck = 1'b1;
    spiSdi = 1'b0;
  end
  // ====
  // frame transfer
  // idle high sck, msb first; each sck phase lasts two clocks so edge sampling never misses one
  // reply bits move on each sck fall, so each is taken just before that fall
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    @(negedge clk_sys);
    spiCsN = 1'b0;
    @(negedge clk_sys);
    for (int i = 39; i >= 0; i--) begin
      rx[i] = spiSdo;
      spiSck = 1'b0;
      spiSdi = tx[i];
      repeat (2) @(negedge clk_sys);
      spiSck = 1'b1;
      repeat (2) @(negedge clk_sys);
    end
    spiCsN = 1'b1;
    // released line has no pull, so show the inverse of the last bit
    spiSdi = ~spiSdi;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule

/* File: test/tb_gdf_global_flags.sv */
// self-checking testbench for the global flag block
`timescale 1ns/1ps
`include "gdf_params.svh"
module tb_gdf_global_flags;
  logic clk_sys, rst, spiCsN, spiSck, spiSdi, spiSdo, drvEnable, tempPrewarn, tempShutdown, pumpUv;
  logic [5:0] shortDetect;
  logic [2:0] highSideGateInput, lowSideGateInput, highSideGateOut, lowSideGateOut;
  logic ampPowerDown, testOutEnable, faultStatus;
  logic [1:0] testSelect;
  logic [39:0] rx;
  int errTotal, compares;
  gdf_global_flags dut (.*);
  gdf_host_model host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ====
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    host.xfer({1'b1, a, d}, rx);
  endtask
  // status byte of any reply carries the flags as they stood at frame start
  task automatic fl(input logic [3:0] exp);
    host.xfer({1'b0, `GDF_ADDR_FLAGS, 32'h0}, rx);
    chk("flags", rx[35:32], exp);
  endtask
  task automatic doReset();
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
    cyc(1);
  endtask
  task automatic setAll();
    tempPrewarn = 1'b1;
    tempShutdown = 1'b1;
    pumpUv = 1'b1;
    cyc(2);
    tempPrewarn = 1'b0;
    pumpUv = 1'b0;
  endtask
  // ====
  // scenarios
  task automatic sReset();
    doReset();
    chk("testSel", testSelect, 2'h3);
    chk("ampOff", ampPowerDown, 1'b0);
    chk("fault", faultStatus, 1'b0);
    host.xfer(40'h0, rx);
    chk("rstFlag", rx[35:32], 4'h1);
    chk("rstReply", rx[31:0], 32'h1);
  endtask
  task automatic sRstClear();
    drvEnable = 1'b0;
    wr(`GDF_ADDR_FLAGS, 32'h1);
    fl(4'h1);
    drvEnable = 1'b1;
    cyc(2);
    wr(`GDF_ADDR_FLAGS, 32'h1);
    fl(4'h0);
  endtask
  task automatic sW1c();
    setAll();
    fl(4'hE);
    chk("fault", faultStatus, 1'b1);
    wr(`GDF_ADDR_FLAGS, 32'h0);
    fl(4'hE);
    wr(`GDF_ADDR_FLAGS, 32'h6);
    fl(4'hC);
    tempShutdown = 1'b0;
    cyc(2);
    chk("faultHeld", faultStatus, 1'b1);
    wr(`GDF_ADDR_FLAGS, 32'h4);
    fl(4'h8);
    chk("fault", faultStatus, 1'b0);
    pumpUv = 1'b1;
    wr(`GDF_ADDR_FLAGS, 32'h8);
    pumpUv = 1'b0;
    fl(4'h8);
    wr(`GDF_ADDR_FLAGS, 32'h8);
    fl(4'h0);
  endtask
  task automatic sToggle();
    doReset();
    setAll();
    tempShutdown = 1'b0;
    fl(4'hF);
    drvEnable = 1'b0;
    cyc(2);
    drvEnable = 1'b1;
    cyc(2);
    fl(4'h3);
  endtask
  task automatic sConfig();
    wr(`GDF_ADDR_CONF, 32'h40);
    chk("ampOff", ampPowerDown, 1'b1);
    host.xfer(40'h0, rx);
    chk("confRead", rx[31:0], 32'h40);
    for (int d = 0; d < 4; d++) begin
      wr(`GDF_ADDR_DTIME, d);
      wr(`GDF_ADDR_CONF, 32'h80);
      chk("testOn", testOutEnable, 1'b1);
      chk("testSel", testSelect, d[1:0]);
    end
    // host leaves test mode off for normal use
    wr(`GDF_ADDR_CONF, 32'h0);
    chk("testOn", testOutEnable, 1'b0);
    chk("testSel", testSelect, 2'h3);
    chk("ampOff", ampPowerDown, 1'b0);
    wr(7'h55, 32'hFFFF_FFFF);
    host.xfer(40'h0, rx);
    chk("unmapped", rx[31:0], 32'h0);
  endtask
  task automatic sShort();
    lowSideGateInput = 3'h1;
    cyc(2);
    chk("lsOut", lowSideGateOut, 3'h1);
    chk("hsOut", highSideGateOut, 3'h7);
    shortDetect = 6'h01;
    cyc(2);
    shortDetect = 6'h00;
    cyc(2);
    chk("lsOut", lowSideGateOut, 3'h0);
    chk("faultShort", faultStatus, 1'b1);
    wr(`GDF_ADDR_FLAGS, 32'hF);
    chk("lsOut", lowSideGateOut, 3'h0);
    // gate input must go off before the latched short is released
    lowSideGateInput = 3'h0;
    cyc(2);
    lowSideGateInput = 3'h1;
    cyc(2);
    chk("lsOut", lowSideGateOut, 3'h1);
    chk("faultFree", faultStatus, 1'b0);
  endtask
  // ====
  // main sequence
  task automatic testDone();
    if (errTotal == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    drvEnable = 1'b1;
    tempPrewarn = 1'b0;
    tempShutdown = 1'b0;
    pumpUv = 1'b0;
    shortDetect = 6'h00;
    highSideGateInput = 3'h7;
    lowSideGateInput = 3'h0;
    errTotal = 0;
    compares = 0;
    sReset();
    sRstClear();
    sW1c();
    sToggle();
    sConfig();
    sShort();
    testDone();
  end
endmodule
